// file: rtl/scl_strap_latch.sv
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module scl_strap_latch
  import scl_pkg::*;
(
  input  wire logic       sys_clk_i,      // Device clock
  input  wire logic       reset_i,        // Async reset, high
  input  wire scl_strap_s strap_pin_i,    // Pad levels
  output scl_strap_s      strap_out_o,    // Pad drive values
  output scl_strap_s      strap_oe_o,     // Pad output enables
  output logic            strap_pull_o,   // Weak pulls enabled
  input  wire scl_strap_s func_out_i,     // Normal-mode pad data
  input  wire logic       fiber_select_i, // Fiber select pin
  input  wire logic [4:0] reg_addr_i,     // Register address
  input  wire logic [15:0] reg_wdata_i,   // Write data
  input  wire logic       reg_wr_i,       // Write strobe
  input  wire logic       reg_rd_i,       // Read strobe
  output logic [15:0]     reg_rdata_o,    // Read data, next cycle
  output scl_cfg_s        cfg_o,          // Live configuration
  output logic            strap_done_o    // Straps captured
);

  scl_strap_s  sync1_r;
  scl_strap_s  sync2_r;
  scl_strap_s  lat_r;
  logic        fib1_r;
  logic        fib2_r;
  logic        fib_lat_r;
  logic        phase_r;
  logic [2:0]  cnt_r;
  logic        load_r;
  logic        speed_r;
  logic        aneg_r;
  logic        iso_r;
  logic        full_r;
  logic [3:0]  adv_r;
  logic        fef_r;
  logic [2:0]  addr_r;
  scl_strap_s  oe_r;
  scl_strap_s  out_r;
  logic        pull_r;
  logic [15:0] rdata_r;
  scl_cfg_s    cfg_r;
  logic        done_r;
  logic [15:0] ctrl_val;
  logic [15:0] adv_val;
  logic        wr_ctrl;
  logic        wr_adv;

  // Pads are asynchronous to sys_clk, so two stages before any use
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
      fib1_r  <= 1'b0;
      fib2_r  <= 1'b0;
    end else begin
      sync1_r <= strap_pin_i;
      sync2_r <= sync1_r;
      fib1_r  <= fiber_select_i;
      fib2_r  <= fib1_r;
    end
  end

  // Sampling window: open during reset and a few cycles after, so the
  // synchronisers flush their reset value before the last capture
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_r <= 1'b1;
      cnt_r   <= SCL_SETTLE_CYC;
      load_r  <= 1'b0;
    end else begin
      load_r <= 1'b0;
      if (phase_r) begin
        if (cnt_r == 3'h0) begin
          phase_r <= 1'b0;
          load_r  <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 3'h1;
        end
      end
    end
  end

  // Capture while the window is open, then freeze
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lat_r     <= '0;
      fib_lat_r <= 1'b0;
    end else if (phase_r) begin
      lat_r     <= sync2_r;
      fib_lat_r <= fib2_r;
    end
  end

  // Pad direction: pulled inputs in the window, outputs after it
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      oe_r   <= '0;
      out_r  <= '0;
      pull_r <= 1'b1;
    end else begin
      oe_r   <= phase_r ? '0 : '1;
      out_r  <= func_out_i;
      pull_r <= phase_r;
    end
  end

  assign wr_ctrl = reg_wr_i && (reg_addr_i == SCL_REG_CTRL);
  assign wr_adv  = reg_wr_i && (reg_addr_i == SCL_REG_ADV);

  // Control bits: strap load at window close, software writes later
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      speed_r <= SCL_RST_SPEED;
      aneg_r  <= SCL_RST_ANEG;
      iso_r   <= SCL_RST_ISO;
      full_r  <= SCL_RST_FULL;
    end else if (load_r) begin
      // Fiber runs at 100 only; the shared strap is fault enable there
      speed_r <= fib_lat_r ? 1'b1 : lat_r.shared;
      aneg_r  <= lat_r.autoneg && !fib_lat_r;
      iso_r   <= lat_r.isolate;
      full_r  <= !lat_r.duplex;
    end else if (wr_ctrl) begin
      speed_r <= reg_wdata_i[SCL_CTRL_SPEED];
      aneg_r  <= reg_wdata_i[SCL_CTRL_ANEG];
      iso_r   <= reg_wdata_i[SCL_CTRL_ISO];
      full_r  <= reg_wdata_i[SCL_CTRL_DUPLEX];
    end
  end

  // Advertised abilities: 10 Mbit strap drops the 100 Mbit abilities
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      adv_r <= SCL_RST_ADV;
    end else if (load_r) begin
      adv_r <= (fib_lat_r || lat_r.shared) ? 4'hF : 4'h3;
    end else if (wr_adv) begin
      adv_r <= reg_wdata_i[SCL_ADV_100FD:SCL_ADV_10HD];
    end
  end

  // Fault enable and address are strap-only
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fef_r  <= 1'b0;
      addr_r <= 3'h0;
    end else if (load_r) begin
      fef_r  <= fib_lat_r && lat_r.shared;
      addr_r <= lat_r.addr;
    end
  end

  // Register images
  always_comb begin
    ctrl_val                 = 16'h0000;
    ctrl_val[SCL_CTRL_SPEED]  = speed_r;
    ctrl_val[SCL_CTRL_ANEG]   = aneg_r;
    ctrl_val[SCL_CTRL_ISO]    = iso_r;
    ctrl_val[SCL_CTRL_DUPLEX] = full_r;
    adv_val                  = 16'h0000;
    adv_val[SCL_ADV_100FD:SCL_ADV_10HD] = adv_r;
    adv_val[4:0]             = SCL_ADV_SEL;
  end

  // Read port answers one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_r <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        SCL_REG_CTRL:  rdata_r <= ctrl_val;
        SCL_REG_ADV:   rdata_r <= adv_val;
        SCL_REG_STRAP: rdata_r <= {8'h00, fib_lat_r, fef_r, 1'b0, 2'b00, addr_r};
        default:       rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  // Registered configuration outputs
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_r  <= '0;
      done_r <= 1'b0;
    end else begin
      cfg_r.speed_100        <= speed_r;
      cfg_r.full_duplex      <= full_r;
      cfg_r.autoneg_en       <= aneg_r;
      cfg_r.isolate          <= iso_r;
      cfg_r.far_end_fault_en <= fef_r;
      cfg_r.fiber            <= fib_lat_r;
      cfg_r.phy_addr         <= {2'b00, addr_r};
      done_r                 <= !phase_r && !load_r;  // Waits out the load edge so done rises on the same edge that cfg_o turns valid
    end
  end

  assign strap_out_o  = out_r;
  assign strap_oe_o   = oe_r;
  assign strap_pull_o = pull_r;
  assign reg_rdata_o  = rdata_r;
  assign cfg_o        = cfg_r;
  assign strap_done_o = done_r;

  // Checks
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  property p_hold;
    !phase_r && !load_r |=> $stable(lat_r) && $stable(addr_r);
  endproperty
  a_hold: assert property (p_hold) else $error("straps changed after window");

  property p_dir;
    phase_r |=> (oe_r == '0) && pull_r;
  endproperty
  a_dir: assert property (p_dir) else $error("pad driven in window");

  property p_copper_speed;
    load_r && !fib_lat_r |=> speed_r == $past(lat_r.shared);
  endproperty
  a_copper_speed: assert property (p_copper_speed) else $error("copper speed wrong");

  property p_speed10;
    load_r && !fib_lat_r && !lat_r.shared |=> !speed_r ##2 !cfg_o.speed_100;
  endproperty
  a_speed10: assert property (p_speed10) else $error("10M strap lost");

  property p_ctrl_load;
    $fell(phase_r) |-> ##1 (speed_r == (fib_lat_r | lat_r.shared));
  endproperty
  a_ctrl_load: assert property (p_ctrl_load) else $error("bit 13 not loaded");

  property p_adv;
    load_r |=> adv_r[3] == ($past(lat_r.shared) | $past(fib_lat_r)) && adv_r[1:0] == 2'b11;
  endproperty
  a_adv: assert property (p_adv) else $error("advert wrong");

  property p_fef;
    load_r |=> fef_r == ($past(fib_lat_r) && $past(lat_r.shared));
  endproperty
  a_fef: assert property (p_fef) else $error("fault enable wrong");

  property p_duplex;
    load_r |=> full_r != $past(lat_r.duplex);
  endproperty
  a_duplex: assert property (p_duplex) else $error("duplex wrong");

  property p_aneg;
    load_r && !fib_lat_r |=> aneg_r == $past(lat_r.autoneg);
  endproperty
  a_aneg: assert property (p_aneg) else $error("autoneg wrong");

  property p_fiber_aneg;
    load_r && fib_lat_r |=> !aneg_r ##2 !cfg_o.autoneg_en;
  endproperty
  a_fiber_aneg: assert property (p_fiber_aneg) else $error("fiber autoneg on");

  property p_iso;
    load_r |=> iso_r == $past(lat_r.isolate);
  endproperty
  a_iso: assert property (p_iso) else $error("isolate wrong");

  property p_addr;
    cfg_o.phy_addr == {2'b00, $past(addr_r)};
  endproperty
  a_addr: assert property (p_addr) else $error("address top bits set");

  property p_keep;
    !load_r && !wr_ctrl |=> $stable(ctrl_val);
  endproperty
  a_keep: assert property (p_keep) else $error("control drifted");

  // Done must trail the load edge, or a consumer would latch stale cfg_o
  property p_done;
    load_r |=> !done_r ##1 done_r;
  endproperty
  a_done: assert property (p_done) else $error("done ahead of cfg");

  property p_drive;
    !phase_r && !load_r |-> (oe_r == '1) && !pull_r;
  endproperty
  a_drive: assert property (p_drive) else $error("pad not driven after window");

  property p_fiber_speed;
    load_r && fib_lat_r |=> speed_r && (adv_r == 4'hF);
  endproperty
  a_fiber_speed: assert property (p_fiber_speed) else $error("fiber speed or advert wrong");

  // Software writes only land when no strap load competes for the edge
  property p_sw_speed;
    wr_ctrl && !load_r |=> speed_r == $past(reg_wdata_i[SCL_CTRL_SPEED]);
  endproperty
  a_sw_speed: assert property (p_sw_speed) else $error("speed write lost");

  property p_sw_adv;
    wr_adv && !load_r |=> adv_r == $past(reg_wdata_i[SCL_ADV_100FD:SCL_ADV_10HD]);
  endproperty
  a_sw_adv: assert property (p_sw_adv) else $error("advert write lost");

endmodule

// file: rtl/scl_pkg.sv
// Notes on behaviour
// - Every strap pin is sampled around reset and the sampled values are held after reset.
// - Strap pins are weakly pulled inputs during reset and driven outputs otherwise; the logic keeps them pulled inputs until the settle window closes.
// - With fiber select low the shared strap is read as the speed selection.
// - The speed strap high means 100 Mbit/s, the pulled default, and low means 10 Mbit/s.
// - The sampled speed is loaded into control register bit 13 when reset ends; the logic loads it when the settle window closes.
// - The sampled speed sets the speed capabilities in advertisement register 4h.
// - With fiber select high the shared strap enables far-end fault when high, disables when low.
// - The duplex strap high means half duplex, low full duplex, loaded into control bit 8.
// - The autoneg strap high enables negotiation, low disables it, loaded into control bit 12.
// - In fiber mode negotiation is forced off whatever the autoneg strap shows.
// - The isolate strap is loaded into control bit 10, high isolates, low is the default.
// - The station address straps give address bits 2..0 and bits 4..3 are always zero.
package scl_pkg;

  // Register offsets on the management port
  localparam logic [4:0] SCL_REG_CTRL  = 5'h00;
  localparam logic [4:0] SCL_REG_ADV   = 5'h04;
  localparam logic [4:0] SCL_REG_STRAP = 5'h10;

  // Control register field positions
  localparam int SCL_CTRL_SPEED  = 13;
  localparam int SCL_CTRL_ANEG   = 12;
  localparam int SCL_CTRL_ISO    = 10;
  localparam int SCL_CTRL_DUPLEX = 8;

  // Advertisement field positions and fixed selector
  localparam int         SCL_ADV_100FD = 8;
  localparam int         SCL_ADV_100HD = 7;
  localparam int         SCL_ADV_10FD  = 6;
  localparam int         SCL_ADV_10HD  = 5;
  localparam logic [4:0] SCL_ADV_SEL   = 5'h01;

  // Values after reset follow the internal pull defaults
  localparam logic       SCL_RST_SPEED = 1'b1;
  localparam logic       SCL_RST_ANEG  = 1'b1;
  localparam logic       SCL_RST_ISO   = 1'b0;
  localparam logic       SCL_RST_FULL  = 1'b0;
  localparam logic [3:0] SCL_RST_ADV   = 4'hF;

  // Strap settle window after reset release
  localparam int         SCL_CLK_NS     = 25;
  localparam int         SCL_SETTLE_NS  = 100;
  localparam int         SCL_SETTLE_INT = (SCL_SETTLE_NS + SCL_CLK_NS - 1) / SCL_CLK_NS;
  localparam logic [2:0] SCL_SETTLE_CYC = 3'(SCL_SETTLE_INT);

  // One bit per strap pin
  typedef struct packed {
    logic       shared;   // Speed or far-end fault
    logic       duplex;
    logic       autoneg;
    logic       isolate;
    logic [2:0] addr;     // Station address
  } scl_strap_s;

  // Configuration seen by the rest of the transceiver
  typedef struct packed {
    logic       speed_100;
    logic       full_duplex;
    logic       autoneg_en;
    logic       isolate;
    logic       far_end_fault_en;
    logic       fiber;
    logic [4:0] phy_addr;
  } scl_cfg_s;

endpackage

// file: verification/scl_board_model.sv
`timescale 1ns/1ps
module scl_board_model
  import scl_pkg::*;
(
  input  wire scl_strap_s board_i,  // Resistor levels on the board
  input  wire logic       fitted_i, // Resistors present
  input  wire scl_strap_s out_i,    // Device pad drive
  input  wire scl_strap_s oe_i,     // Device pad enables
  input  wire logic       pull_i,   // Device weak pulls on
  output scl_strap_s      pad_o     // Resolved pad level
);
  // Device weak pull levels, seen only when no resistor is fitted
  localparam scl_strap_s PULL_LVL = 7'h71;

  // Device drive wins over resistors, resistors over weak pulls
  // A pad nobody holds reads inverted, so a stale value never passes
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (oe_i[i]) begin
        pad_o[i] = out_i[i];
      end else if (fitted_i) begin
        pad_o[i] = board_i[i];
      end else if (pull_i) begin
        pad_o[i] = PULL_LVL[i];
      end else begin
        pad_o[i] = ~out_i[i];
      end
    end
  end
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import scl_pkg::*;
  logic        sys_clk_i;
  logic        reset_i;
  logic        fiber_select_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic        fitted;
  logic        rd_d;
  logic [4:0]  reg_addr_i;
  logic [15:0] reg_wdata_i;
  logic [15:0] reg_rdata_o;
  logic [15:0] stat_e;
  logic [15:0] w;
  scl_strap_s  board;
  scl_strap_s  pad;
  scl_strap_s  func_out_i;
  scl_strap_s  strap_out_o;
  scl_strap_s  strap_oe_o;
  logic        strap_pull_o;
  logic        strap_done_o;
  scl_cfg_s    cfg_o;
  int          bad_count;
  int          checked;
  int          seed;
  logic [15:0] exp_q[$];

  scl_strap_latch u_dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .strap_pin_i(pad),
    .strap_out_o(strap_out_o), .strap_oe_o(strap_oe_o), .strap_pull_o(strap_pull_o),
    .func_out_i(func_out_i), .fiber_select_i(fiber_select_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .cfg_o(cfg_o), .strap_done_o(strap_done_o));

  scl_board_model u_board (.board_i(board), .fitted_i(fitted), .out_i(strap_out_o),
    .oe_i(strap_oe_o), .pull_i(strap_pull_o), .pad_o(pad));

  // Free-running 40 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Register port master: one-cycle strobes, expected read data noted in order
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge sys_clk_i);
    exp_q.push_back(e);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge sys_clk_i) rd_d <= reg_rd_i;
  always @(negedge sys_clk_i) begin
    if (rd_d && exp_q.size() > 0) begin
      cmp(reg_rdata_o, exp_q.pop_front(), "rdata");
    end
  end

  // One reset with given board straps, then the loaded image is checked
  task automatic strap_run(input scl_strap_s b, input logic f, input logic fit);
    scl_strap_s s;
    scl_cfg_s   ce;
    logic [15:0] ctrl_e;
    s = fit ? b : 7'h71;
    ce.speed_100 = f | s.shared;
    ce.full_duplex = ~s.duplex;
    ce.autoneg_en = ~f & s.autoneg;
    ce.isolate = s.isolate;
    ce.far_end_fault_en = f & s.shared;
    ce.fiber = f;
    ce.phy_addr = {2'b00, s.addr};
    ctrl_e = {2'b00, ce.speed_100, ce.autoneg_en, 1'b0, ce.isolate, 1'b0, ce.full_duplex, 8'h00};
    stat_e = {8'h00, f, ce.far_end_fault_en, 3'b000, s.addr};
    @(posedge sys_clk_i);
    board <= b;
    fitted <= fit;
    fiber_select_i <= f;
    reset_i <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    cmp(16'(strap_oe_o), 16'h0000, "oe in reset");
    cmp(16'(strap_pull_o), 16'h0001, "pull in reset");
    @(posedge sys_clk_i);
    reset_i <= 1'b0;
    repeat (7) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    cmp(16'(cfg_o), 16'(ce), "cfg");
    cmp(16'({strap_pull_o, strap_done_o, strap_oe_o}), 16'h00FF, "oe pull done");
    rd(SCL_REG_CTRL, ctrl_e);
    rd(SCL_REG_ADV, (ce.speed_100 ? 16'h01E1 : 16'h0061));
    rd(SCL_REG_STRAP, stat_e);
    board <= ~b;
    fiber_select_i <= ~f;
    func_out_i <= 7'($random(seed));
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    cmp(16'(strap_out_o), 16'(func_out_i), "pad drive");
    rd(SCL_REG_CTRL, ctrl_e);
    rd(SCL_REG_STRAP, stat_e);
  endtask

  // Watchdog sized well beyond the expected run
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    bad_count++;
    report_and_stop();
  end

  initial begin
    seed = 32'h307E;
    reset_i = 1'b1;
    fiber_select_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 5'h00;
    reg_wdata_i = 16'h0000;
    board = 7'h71;
    fitted = 1'b1;
    func_out_i = 7'h00;
    bad_count = 0;
    checked = 0;
    strap_run(7'h00, 1'b0, 1'b0);
    strap_run(7'h00, 1'b1, 1'b0);
    strap_run(7'h00, 1'b0, 1'b1);
    strap_run(7'h7F, 1'b1, 1'b1);
    strap_run(7'h40, 1'b1, 1'b1);
    strap_run(7'h3F, 1'b1, 1'b1);
    for (int k = 0; k < 6; k++) begin
      strap_run(7'($random(seed)), k[0], 1'b1);
    end
    // Software overwrites strap-loaded bits; status stays read-only
    w = 16'($random(seed));
    wr(SCL_REG_CTRL, w);
    rd(SCL_REG_CTRL, w & 16'h3500);
    @(negedge sys_clk_i);
    cmp(16'(cfg_o.speed_100), 16'(w[13]), "cfg after write");
    wr(SCL_REG_ADV, ~w);
    rd(SCL_REG_ADV, (~w & 16'h01E0) | 16'h0001);
    wr(SCL_REG_STRAP, w);
    rd(SCL_REG_STRAP, stat_e);
    rd(5'h1F, 16'h0000);
    repeat (3) @(posedge sys_clk_i);
    report_and_stop();
  end
endmodule
